// [core/liu_fifo_mem.sv]
// Elastic bit memory of the jitter attenuator
`timescale 1ns/10ps
`default_nettype none
module liu_fifo_mem (
  clk,
  sys_rst,
  wr_en,
  wr_addr,
  wr_data,
  rd_addr,
  rd_data
);
  import liu_pkg::*;
  input wire logic clk;
  input wire logic sys_rst;
  input wire logic wr_en;
  input wire logic [liu_pkg::LIU_AW-1:0] wr_addr;
  input wire logic wr_data;
  input wire logic [liu_pkg::LIU_AW-1:0] rd_addr;
  output logic rd_data;

  logic [LIU_MEM_DEPTH-1:0] mem_ff;

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_ff[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data <= 1'b0;
    end else begin
      rd_data <= mem_ff[rd_addr];
    end
  end
endmodule : liu_fifo_mem
`default_nettype wire

// [core/liu_pin_ctrl.sv]
// Hardware pin control: reset filter, attenuator select and driver float
`timescale 1ns/10ps
`default_nettype none
module liu_pin_ctrl (
  clk,
  sys_rst,
  rst_pin_n,
  hw_mode,
  jitter_atten_sel,
  tx_driver_float,
  rx_in,
  tx_in,
  rx_out,
  tx_out,
  tx_drive_oe,
  chip_rst,
  ja_cfg
);
  import liu_pkg::*;
  input wire logic clk;
  input wire logic sys_rst;
  input wire logic rst_pin_n;
  input wire logic hw_mode;
  input wire logic [1:0] jitter_atten_sel;
  input wire logic tx_driver_float;
  input wire liu_pkg::liu_bit_t rx_in;
  input wire liu_pkg::liu_bit_t tx_in;
  output liu_pkg::liu_bit_t rx_out;
  output liu_pkg::liu_bit_t tx_out;
  output logic tx_drive_oe;
  output logic chip_rst;
  output liu_pkg::liu_ja_cfg_t ja_cfg;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [4:0] pin_s1_ff;
  logic [4:0] pin_s2_ff;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s1_ff <= 5'h1F;
      pin_s2_ff <= 5'h1F;
    end else begin
      pin_s1_ff <= {rst_pin_n, hw_mode, jitter_atten_sel, tx_driver_float};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  logic rst_n_s;
  logic hw_s;
  logic [1:0] sel_s;
  logic float_s;
  assign rst_n_s = pin_s2_ff[4];
  assign hw_s = pin_s2_ff[3];
  assign sel_s = pin_s2_ff[2:1];
  assign float_s = pin_s2_ff[0];

  // ----------------------------------------
  // Reset pulse width filter
  // ----------------------------------------
  logic [5:0] rst_cnt_ff;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_cnt_ff <= 6'h00;
    end else if (rst_n_s) begin
      rst_cnt_ff <= 6'h00;
    end else if (rst_cnt_ff != LIU_RST_CNT_MAX) begin
      rst_cnt_ff <= rst_cnt_ff + 6'h01;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      chip_rst <= 1'b1;
    end else begin
      chip_rst <= (rst_cnt_ff == LIU_RST_CNT_MAX);
    end
  end

  // ----------------------------------------
  // Attenuator select decode
  // ----------------------------------------
  liu_ja_sel_t sel_eff;
  liu_ja_cfg_t nxt_cfg;

  always_comb begin
    sel_eff = hw_s ? liu_ja_sel_t'(sel_s) : LIU_JA_OFF;
    nxt_cfg = '0;
    unique case (sel_eff)
      LIU_JA_OFF: begin
        nxt_cfg = '0;
      end
      LIU_JA_RX_BROAD: begin
        nxt_cfg.in_rx = 1'b1;
        nxt_cfg.depth = LIU_DEPTH_BROAD_W;
      end
      LIU_JA_RX_NARROW: begin
        nxt_cfg.in_rx = 1'b1;
        nxt_cfg.narrow_bw = 1'b1;
        nxt_cfg.depth = LIU_DEPTH_NARROW_W;
      end
      LIU_JA_TX_NARROW: begin
        nxt_cfg.in_tx = 1'b1;
        nxt_cfg.narrow_bw = 1'b1;
        nxt_cfg.depth = LIU_DEPTH_NARROW_W;
      end
    endcase
  end

  logic cfg_chg;
  assign cfg_chg = (nxt_cfg != ja_cfg);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ja_cfg <= '0;
    end else if (chip_rst) begin
      ja_cfg <= '0;
    end else begin
      ja_cfg <= nxt_cfg;
    end
  end

  // ----------------------------------------
  // Elastic store pointers
  // ----------------------------------------
  logic [LIU_AW-1:0] wr_ptr_ff;
  logic [LIU_AW-1:0] rd_ptr_ff;
  logic [LIU_AW-1:0] half_depth;
  liu_bit_t ja_in;
  logic ja_on;
  logic mem_rd;

  assign ja_on = ja_cfg.in_rx | ja_cfg.in_tx;
  assign ja_in = ja_cfg.in_tx ? tx_in : rx_in;
  assign half_depth = ja_cfg.narrow_bw ? 7'h40 : 7'h20;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_ff <= '0;
    end else if (chip_rst || !ja_on || cfg_chg) begin
      wr_ptr_ff <= '0;
    end else if (ja_in.clk_en) begin
      wr_ptr_ff <= (wr_ptr_ff + 7'h01) & (ja_cfg.depth[6:0] - 7'h01 | {ja_cfg.depth[7], 6'h00});
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_ptr_ff <= '0;
    end else if (chip_rst || !ja_on || cfg_chg) begin
      rd_ptr_ff <= '0 - half_depth;
    end else if (ja_in.clk_en) begin
      rd_ptr_ff <= (rd_ptr_ff + 7'h01) & (ja_cfg.depth[6:0] - 7'h01 | {ja_cfg.depth[7], 6'h00});
    end
  end

  liu_fifo_mem u_mem (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(ja_on & ja_in.clk_en),
    .wr_addr(wr_ptr_ff),
    .wr_data(ja_in.data),
    .rd_addr(rd_ptr_ff & (ja_cfg.depth[6:0] - 7'h01 | {ja_cfg.depth[7], 6'h00})),
    .rd_data(mem_rd)
  );

  logic ja_clk_d_ff;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ja_clk_d_ff <= 1'b0;
    end else begin
      ja_clk_d_ff <= ja_on & ja_in.clk_en;
    end
  end

  // ----------------------------------------
  // Path outputs and driver enable
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_out <= '0;
      tx_out <= '0;
    end else begin
      rx_out <= ja_cfg.in_rx ? liu_bit_t'({mem_rd, ja_clk_d_ff}) : rx_in;
      tx_out <= ja_cfg.in_tx ? liu_bit_t'({mem_rd, ja_clk_d_ff}) : tx_in;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_drive_oe <= 1'b0;
    end else begin
      tx_drive_oe <= ~float_s & ~chip_rst;
    end
  end
endmodule : liu_pin_ctrl
`default_nettype wire

// [core/liu_pkg.sv]
// Package of constants and types for the line interface pin control block
package liu_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int LIU_CLK_PERIOD_PS = 4000;
  localparam int LIU_RST_MIN_NS = 100;
  localparam int LIU_RST_CYCLES = (LIU_RST_MIN_NS * 1000) / LIU_CLK_PERIOD_PS + 1;
  localparam logic [5:0] LIU_RST_CNT_MAX = 6'(LIU_RST_CYCLES);

  // ----------------------------------------
  // Attenuator depths
  // ----------------------------------------
  localparam int LIU_DEPTH_BROAD = 64;
  localparam int LIU_DEPTH_NARROW = 128;
  localparam int LIU_MEM_DEPTH = 128;
  localparam int LIU_AW = 7;
  localparam logic [7:0] LIU_DEPTH_BROAD_W = 8'h40;
  localparam logic [7:0] LIU_DEPTH_NARROW_W = 8'h80;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    LIU_JA_OFF = 2'b00,
    LIU_JA_RX_BROAD = 2'b01,
    LIU_JA_RX_NARROW = 2'b10,
    LIU_JA_TX_NARROW = 2'b11
  } liu_ja_sel_t;

  typedef struct packed {
    logic in_rx;
    logic in_tx;
    logic narrow_bw;
    logic [7:0] depth;
  } liu_ja_cfg_t;

  typedef struct packed {
    logic data;
    logic clk_en;
  } liu_bit_t;
endpackage : liu_pkg

// [tb/liu_brd_model.sv]
// Board controller model that drives the control pins
`timescale 1ns/10ps
`default_nettype none
module liu_brd_model (
  input wire logic clk,
  input wire logic obey,
  output var logic rst_pin_n,
  output var logic hw_mode,
  output logic [1:0] jitter_atten_sel,
  output var logic tx_driver_float
);
  logic [1:0] sel_req;
  assign jitter_atten_sel = (hw_mode || !obey) ? sel_req : 2'h0;
  initial {rst_pin_n, hw_mode, sel_req, tx_driver_float} = 5'b11000;
  // Pin word: reset, mode, select, float
  task automatic drive(input logic [4:0] v);
    @(posedge clk);
    #1;
    {rst_pin_n, hw_mode, sel_req, tx_driver_float} = v;
  endtask : drive
endmodule : liu_brd_model
`default_nettype wire

// [tb/liu_pc_properties.sv]
// Concurrent checks of the pin control block
`timescale 1ns/10ps
`default_nettype none
module liu_pc_properties (
  input wire logic clk, sys_rst, rst_pin_n, hw_mode, tx_driver_float, tx_drive_oe, chip_rst,
  input wire logic [1:0] jitter_atten_sel,
  input wire liu_pkg::liu_bit_t rx_in, tx_in, rx_out, tx_out,
  input wire liu_pkg::liu_ja_cfg_t ja_cfg
);
  import liu_pkg::*;
  wire [1:0] s = jitter_atten_sel;
  liu_ja_cfg_t exp_cfg;
  logic [5:0] lo_ff;
  assign exp_cfg = (s == 2'h0) ? '0 : {~&s, &s, s[1], s[1] ? LIU_DEPTH_NARROW_W : LIU_DEPTH_BROAD_W};
  // Consecutive low samples of the reset pin
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) lo_ff <= 6'h00;
    else lo_ff <= rst_pin_n ? 6'h00 : lo_ff + 6'(lo_ff != 6'h3F);
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_float_off: assert property (tx_driver_float [*4] |=> !tx_drive_oe) else $error("oe on");
  a_drive_on: assert property ((!tx_driver_float && !chip_rst) [*5] |=> tx_drive_oe) else $error("oe off");
  a_sel_ignored: assert property ((!hw_mode) [*4] |=> ja_cfg == '0) else $error("cfg in sw mode");
  a_sel_decode: assert property ((hw_mode && !chip_rst && $stable(s)) [*5] |=> ja_cfg == $past(exp_cfg))
    else $error("cfg");
  a_rst_short: assert property (rst_pin_n [*5] ##1 !rst_pin_n [*8] |=> !chip_rst) else $error("short rst");
  a_rst_min: assert property ($rose(chip_rst) |-> lo_ff >= 6'h19) else $error("early rst");
  a_rst_long: assert property (lo_ff == 6'h20 |-> chip_rst) else $error("no rst");
  a_bypass_pass: assert property ((ja_cfg == '0 && !chip_rst) [*2] |=>
    tx_out == $past(tx_in) && rx_out == $past(rx_in)) else $error("bypass");
  c_long_rst: cover property (lo_ff == 6'h20);
  c_tx_ja: cover property (ja_cfg.in_tx);
  c_float_data: cover property (!tx_drive_oe && tx_out.clk_en);
endmodule : liu_pc_properties
bind liu_pin_ctrl liu_pc_properties i_props (.*);
`default_nettype wire

// [tb/liu_pin_ctrl_tb.sv]
// Self-checking testbench of the pin control block
`timescale 1ns/10ps
`default_nettype none
module liu_pin_ctrl_tb;
  import liu_pkg::*;
  localparam liu_ja_cfg_t exp_tab [4] = '{11'h000, {3'b100, LIU_DEPTH_BROAD_W},
    {3'b101, LIU_DEPTH_NARROW_W}, {3'b011, LIU_DEPTH_NARROW_W}};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic obey;
  logic rst_pin_n, hw_mode, tx_driver_float, tx_drive_oe, chip_rst;
  logic [1:0] jitter_atten_sel;
  liu_bit_t rx_in;
  liu_bit_t tx_in;
  liu_bit_t rx_out, tx_out;
  liu_ja_cfg_t ja_cfg;
  int mismatches = 0;
  int num_checks = 0;
  always #2 clk = ~clk;
  liu_pin_ctrl i_dut (.*);
  liu_brd_model i_brd (.*);
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim
  task automatic t_decode;
    for (int i = 0; i < 4; i++) begin
      i_brd.drive({2'b11, 2'(i), 1'b0});
      cyc(6);
      chk(ja_cfg, exp_tab[i]);
    end
    obey = 1'b0;
    i_brd.drive(5'b10110);
    cyc(6);
    chk(ja_cfg, 11'h000);
    obey = 1'b1;
    $display("decode done");
  endtask : t_decode
  task automatic t_float;
    i_brd.drive(5'b11001);
    cyc(6);
    chk(11'(tx_drive_oe), 11'h000);
    for (int d = 0; d < 2; d++) begin
      tx_in = {d[0], 1'b1};
      rx_in = {~d[0], 1'b1};
      cyc(1);
      chk(11'({tx_out, rx_out}), 11'({d[0], 1'b1, ~d[0], 1'b1}));
    end
    i_brd.drive(5'b11000);
    cyc(6);
    chk(11'(tx_drive_oe), 11'h001);
    $display("float done");
  endtask : t_float
  task automatic t_reset;
    i_brd.drive(5'b01000);
    cyc(12);
    i_brd.drive(5'b11000);
    cyc(6);
    chk(11'(chip_rst), 11'h000);
    i_brd.drive(5'b01000);
    cyc(32);
    chk(11'(chip_rst), 11'h001);
    i_brd.drive(5'b11000);
    cyc(8);
    chk(11'(chip_rst), 11'h000);
    $display("reset done");
  endtask : t_reset
  initial begin
    obey = 1'b1;
    rx_in = '0;
    tx_in = '0;
    repeat (4) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    cyc(4);
    t_decode;
    t_float;
    t_reset;
    end_sim;
  end
  // About 120 cycles of tests
  initial begin
    #4000;
    mismatches++;
    end_sim;
  end
endmodule : liu_pin_ctrl_tb
`default_nettype wire
